// [rtl/ahps_device.sv]
// Drive end of the host port: register decode, data path, handshakes and interrupts.
`timescale 1ns/1ps
`default_nettype none
`include "ahps_regs.svh"
module ahps_device #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  ahps_if.device bus,
  input wire logic is_drive1,
  input wire logic diag_done,
  input wire ahps_pkg::ahps_byte_t drive_status,
  input wire logic dma_enable,
  input wire logic irq_event,
  input wire logic micro_event,
  input wire ahps_pkg::ahps_byte_t config_register_eleven,
  input wire logic push_valid,
  input wire ahps_pkg::ahps_word_t push_data,
  output logic push_ready,
  output logic host_wr_valid,
  output ahps_pkg::ahps_word_t host_wr_data,
  output logic cmd_valid,
  output ahps_pkg::ahps_byte_t cmd_code,
  output logic dasp_seen,
  output logic pdiag_seen,
  output logic micro_interrupt_line_a_o,
  output logic micro_interrupt_line_a_oe_n,
  output logic micro_interrupt_line_b_o,
  output logic micro_interrupt_line_b_oe_n
);
  import ahps_pkg::*;

  localparam ahps_dev_s DEV_RST = '{dior_q: 1'b1, diow_q: 1'b1, dd_oe_n: 1'b1, iordy: 1'b1,
                                    iocs16_n: 1'b1, mia_oe_n: 1'b1, mib_oe_n: 1'b1,
                                    dasp_oe_n: 1'b1, pdiag_oe_n: 1'b1, default: '0};

  ahps_dev_s dev_reg;
  ahps_dev_s dev_next;
  logic fifo_valid;
  ahps_word_t fifo_data;
  logic pop;
  logic sel_ok;
  logic dma_ok;
  logic data_sel;
  logic rd_fall;
  logic rd_rise;
  logic wr_rise;
  logic status_rd;
  ahps_byte_t rd_val;

  // ------------------------------------------------------------
  // Data buffer toward the host
  // ------------------------------------------------------------
  // A slow host stalls the source through the fill-side ready.
  ahps_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk,
    .rst_n(rst_n & bus.host_interface_reset_in),
    .in_valid(push_valid),
    .in_data(push_data),
    .in_ready(push_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(pop)
  );

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  // Both selects low together is illegal on the cable and is ignored.
  assign sel_ok = (bus.cs_cmd_n ^ bus.cs_ctl_n) & bus.dmack_n;
  assign dma_ok = ~bus.dmack_n & bus.cs_cmd_n & bus.cs_ctl_n;
  assign data_sel = dma_ok | (sel_ok & ~bus.cs_cmd_n & (bus.da == `AHPS_DA_DATA));
  assign rd_fall = dev_reg.dior_q & ~bus.dior_n;
  assign rd_rise = ~dev_reg.dior_q & bus.dior_n;
  assign wr_rise = ~dev_reg.diow_q & bus.diow_n;
  assign status_rd = rd_fall & sel_ok & ~bus.cs_cmd_n & (bus.da == `AHPS_DA_STATUS);

  // Register read value; the control block gives the status at its DEVCTL address and zero elsewhere.
  always_comb begin
    if (!bus.cs_ctl_n) begin
      rd_val = (bus.da == `AHPS_DA_DEVCTL) ? drive_status : 8'h00;
    end else if (bus.da == `AHPS_DA_STATUS) begin
      rd_val = drive_status;
    end else begin
      rd_val = dev_reg.tf[bus.da];
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    dev_next = dev_reg;
    pop = 1'b0;
    dev_next.dior_q = bus.dior_n;
    dev_next.diow_q = bus.diow_n;
    dev_next.wr_valid = 1'b0;
    dev_next.cmd_valid = 1'b0;

    // Word indication follows the address, and DMA masks it off through sel_ok.
    dev_next.iocs16_n = ~(sel_ok & ~bus.cs_cmd_n & (bus.da == `AHPS_DA_DATA));

    // Read start: data words come from the buffer, registers as the low byte.
    if (rd_fall && data_sel) begin
      dev_next.dd_oe_n = 1'b0;
      if (fifo_valid) begin
        pop = 1'b1;
        dev_next.dd_o = fifo_data;
        dev_next.iordy = 1'b1;
      end else begin
        dev_next.rd_pend = 1'b1;
        dev_next.iordy = 1'b0;
      end
    end else if (rd_fall && sel_ok) begin
      dev_next.dd_oe_n = 1'b0;
      dev_next.dd_o = {8'h00, rd_val};
    end

    // A stalled read finishes once a word arrives; an aborted strobe just ends it.
    if (dev_reg.rd_pend) begin
      if (bus.dior_n) begin
        dev_next.rd_pend = 1'b0;
        dev_next.iordy = 1'b1;
      end else if (fifo_valid) begin
        pop = 1'b1;
        dev_next.dd_o = fifo_data;
        dev_next.iordy = 1'b1;
        dev_next.rd_pend = 1'b0;
      end
    end
    if (rd_rise) begin
      dev_next.dd_oe_n = 1'b1;
    end

    // Writes are taken at the end of the strobe, when the host data has settled.
    if (wr_rise && data_sel) begin
      dev_next.wr_valid = 1'b1;
      dev_next.wr_data = bus.dd;
    end else if (wr_rise && sel_ok && !bus.cs_cmd_n) begin
      dev_next.tf[bus.da] = bus.dd[7:0];
      dev_next.cmd_valid = bus.da == `AHPS_DA_STATUS;
    end else if (wr_rise && sel_ok && bus.da == `AHPS_DA_DEVCTL) begin
      dev_next.nien = bus.dd[`AHPS_CTL_NIEN];
      if (bus.dd[`AHPS_CTL_SRST]) begin
        dev_next.irq_pend = 1'b0;
        dev_next.tf = '0;
      end
    end

    // Reading status acknowledges the interrupt, but a new event in that cycle wins.
    if (status_rd) begin
      dev_next.irq_pend = 1'b0;
    end
    if (irq_event) begin
      dev_next.irq_pend = 1'b1;
    end
    dev_next.intrq = dev_next.irq_pend & ~dev_next.nien;

    // DMA request while data waits; the acknowledge then opens dma_ok.
    dev_next.dmarq = dma_enable & fifo_valid;

    // Open-drain micro lines: enable low pulls the line low.
    dev_next.mia_oe_n = ~micro_event;
    dev_next.mib_oe_n = ~(config_register_eleven[`AHPS_CFG11_ROUTE] & dev_reg.intrq);

    // Drive 1 pulls DASP, and PDIAG once diag_done; drive 0 only watches them.
    dev_next.dasp_oe_n = ~is_drive1;
    dev_next.pdiag_oe_n = ~(is_drive1 & diag_done);
    dev_next.dasp_seen = ~is_drive1 & ~bus.dasp;
    dev_next.pdiag_seen = ~is_drive1 & ~bus.pdiag;
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Either the chip reset or the host's own reset clears everything here.
  always_ff @(posedge clk) begin
    if (!rst_n || !bus.host_interface_reset_in) begin
      dev_reg <= DEV_RST;
    end else begin
      dev_reg <= dev_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign bus.dev_dd_o = dev_reg.dd_o;
  assign bus.dev_dd_oe_n = dev_reg.dd_oe_n;
  assign bus.iordy = dev_reg.iordy;
  assign bus.iocs16_n = dev_reg.iocs16_n;
  assign bus.dmarq = dev_reg.dmarq;
  assign bus.host_interrupt_request_out = dev_reg.intrq;
  assign bus.dasp_oe_n = dev_reg.dasp_oe_n;
  assign bus.pdiag_oe_n = dev_reg.pdiag_oe_n;
  assign host_wr_valid = dev_reg.wr_valid;
  assign host_wr_data = dev_reg.wr_data;
  assign cmd_valid = dev_reg.cmd_valid;
  assign cmd_code = dev_reg.tf[`AHPS_DA_STATUS];
  assign dasp_seen = dev_reg.dasp_seen;
  assign pdiag_seen = dev_reg.pdiag_seen;
  assign micro_interrupt_line_a_o = 1'b0;
  assign micro_interrupt_line_a_oe_n = dev_reg.mia_oe_n;
  assign micro_interrupt_line_b_o = 1'b0;
  assign micro_interrupt_line_b_oe_n = dev_reg.mib_oe_n;
endmodule
`default_nettype wire

// [rtl/ahps_regs.svh]
// Register addresses, field positions and timing counts of the host port.
`ifndef AHPS_REGS_SVH
`define AHPS_REGS_SVH
// ------------------------------------------------------------
// Register addresses, field positions and timing
// ------------------------------------------------------------
`define AHPS_DA_DATA 3'h0
`define AHPS_DA_STATUS 3'h7
`define AHPS_DA_DEVCTL 3'h6
`define AHPS_CTL_NIEN 1
`define AHPS_CTL_SRST 2
`define AHPS_CFG11_ROUTE 7
`define AHPS_CLK_NS 100
`define AHPS_STROBE_NS 300
`define AHPS_STROBE_CYC ((`AHPS_STROBE_NS + `AHPS_CLK_NS - 1) / `AHPS_CLK_NS)
`define AHPS_PWRUP_NS 1000
`define AHPS_PWRUP_CYC ((`AHPS_PWRUP_NS + `AHPS_CLK_NS - 1) / `AHPS_CLK_NS)
`endif

// [rtl/ahps_pkg.sv]
// Shared types of the host port design.
package ahps_pkg;
  typedef logic [15:0] ahps_word_t;
  typedef logic [2:0] ahps_addr_t;
  typedef logic [7:0] ahps_byte_t;

  typedef enum logic [2:0] {
    H_RST, H_IDLE, H_DMAWAIT, H_SETUP, H_STROBE, H_RECOVER
  } ahps_host_state_e;

  typedef struct packed {
    logic dior_q;
    logic diow_q;
    logic rd_pend;
    ahps_word_t dd_o;
    logic dd_oe_n;
    logic iordy;
    logic iocs16_n;
    logic dmarq;
    logic irq_pend;
    logic nien;
    logic intrq;
    logic mia_oe_n;
    logic mib_oe_n;
    logic dasp_oe_n;
    logic pdiag_oe_n;
    logic dasp_seen;
    logic pdiag_seen;
    logic [7:0][7:0] tf;
    logic wr_valid;
    ahps_word_t wr_data;
    logic cmd_valid;
  } ahps_dev_s;

  typedef struct packed {
    ahps_host_state_e st;
    logic [7:0] cnt;
    logic cs_cmd_n;
    logic cs_ctl_n;
    ahps_addr_t da;
    logic dior_n;
    logic diow_n;
    logic dmack_n;
    ahps_word_t dd_o;
    logic dd_oe_n;
    logic prst_n;
    logic write;
    logic cmd_ready;
    logic rsp_valid;
    ahps_word_t rsp_data;
    logic irq;
  } ahps_host_s;
endpackage

// [rtl/ahps_if.sv]
// Host port wires between the host controller and the drive.
`timescale 1ns/1ps
`default_nettype none
interface ahps_if;
  logic cs_cmd_n;
  logic cs_ctl_n;
  logic [2:0] da;
  logic dior_n;
  logic diow_n;
  logic dmack_n;
  logic dmarq;
  logic iordy;
  logic iocs16_n;
  logic host_interrupt_request_out;
  logic host_interface_reset_in;
  logic [15:0] host_dd_o;
  logic host_dd_oe_n;
  logic [15:0] dev_dd_o;
  logic dev_dd_oe_n;
  logic dasp_oe_n;
  logic pdiag_oe_n;
  logic peer_dasp_n;
  logic peer_pdiag_n;
  logic [15:0] dd;
  logic dasp;
  logic pdiag;

  // The bus floats high through pull-ups when nobody drives it.
  assign dd = !dev_dd_oe_n ? dev_dd_o : (!host_dd_oe_n ? host_dd_o : 16'hffff);
  // Presence and diagnostic lines are wired-low between both drives.
  assign dasp = dasp_oe_n & peer_dasp_n;
  assign pdiag = pdiag_oe_n & peer_pdiag_n;

  modport device (
    input cs_cmd_n, cs_ctl_n, da, dior_n, diow_n, dmack_n, dd, dasp, pdiag,
    input host_interface_reset_in,
    output dmarq, iordy, iocs16_n, host_interrupt_request_out,
    output dev_dd_o, dev_dd_oe_n, dasp_oe_n, pdiag_oe_n
  );
  modport host (
    output cs_cmd_n, cs_ctl_n, da, dior_n, diow_n, dmack_n, host_dd_o, host_dd_oe_n,
    output host_interface_reset_in,
    input dmarq, iordy, iocs16_n, host_interrupt_request_out, dd
  );
endinterface
`default_nettype wire

// [rtl/ahps_fifo.sv]
// Word FIFO between the drive's data source and the host port.
`timescale 1ns/1ps
`default_nettype none
module ahps_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  // Pointers wrap naturally, so the depth must be a power of two.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic empty;
  } ahps_fifo_s;

  ahps_fifo_s fifo_reg;
  ahps_fifo_s fifo_next;
  logic push;
  logic pop;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  // Flags are registered so both readies come straight from flops.
  always_comb begin
    fifo_next = fifo_reg;
    push = in_valid & ~fifo_reg.full;
    pop = out_ready & ~fifo_reg.empty;
    if (push) begin
      fifo_next.mem[fifo_reg.wp] = in_data;
      fifo_next.wp = fifo_reg.wp + 1'b1;
    end
    if (pop) begin
      fifo_next.rp = fifo_reg.rp + 1'b1;
    end
    fifo_next.cnt = fifo_reg.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    fifo_next.full = fifo_next.cnt == (AW + 1)'(DEPTH);
    fifo_next.empty = fifo_next.cnt == '0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fifo_reg <= '0;
      fifo_reg.empty <= 1'b1;
    end else begin
      fifo_reg <= fifo_next;
    end
  end

  assign in_ready = ~fifo_reg.full;
  assign out_valid = ~fifo_reg.empty;
  assign out_data = fifo_reg.mem[fifo_reg.rp];
endmodule
`default_nettype wire

// [rtl/ahps_host.sv]
// Host end of the port: issues register, DMA and reset cycles to the drive.
`timescale 1ns/1ps
`default_nettype none
`include "ahps_regs.svh"
module ahps_host #(
  parameter int STROBE_CYC = `AHPS_STROBE_CYC,
  parameter int PWRUP_CYC = `AHPS_PWRUP_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  ahps_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic cmd_ctl,
  input wire logic cmd_dma,
  input wire ahps_pkg::ahps_addr_t cmd_addr,
  input wire ahps_pkg::ahps_word_t cmd_wdata,
  input wire logic reset_req,
  output logic rsp_valid,
  output ahps_pkg::ahps_word_t rsp_data,
  output logic irq
);
  import ahps_pkg::*;

  // The drive answers one cycle after a strobe edge, so a one-cycle strobe misreads; three cycles is the minimum here.
  if (STROBE_CYC < 3 || STROBE_CYC > 255 || PWRUP_CYC < 1 || PWRUP_CYC > 255) begin : g_bad
    $error("host timing out of range");
  end

  localparam ahps_host_s HOST_RST = '{st: H_RST, cs_cmd_n: 1'b1, cs_ctl_n: 1'b1, dior_n: 1'b1,
                                      diow_n: 1'b1, dmack_n: 1'b1, dd_oe_n: 1'b1, default: '0};

  ahps_host_s host_reg;
  ahps_host_s host_next;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    host_next = host_reg;
    host_next.rsp_valid = 1'b0;
    host_next.irq = bus.host_interrupt_request_out;
    unique case (host_reg.st)
      H_RST: begin
        // Reset is held for the full power-up time after chip reset, one cycle less after a reset_req, before the port is used.
        host_next.prst_n = 1'b0;
        host_next.cnt = host_reg.cnt + 8'h01;
        if (host_reg.cnt >= 8'(PWRUP_CYC - 1)) begin
          host_next.prst_n = 1'b1;
          host_next.cmd_ready = 1'b1;
          host_next.st = H_IDLE;
        end
      end
      H_IDLE: begin
        if (cmd_valid) begin
          host_next.cmd_ready = 1'b0;
          host_next.write = cmd_write;
          host_next.dd_o = cmd_wdata;
          host_next.dd_oe_n = ~cmd_write;
          host_next.da = cmd_addr;
          if (cmd_dma) begin
            host_next.st = H_DMAWAIT;
          end else begin
            host_next.cs_cmd_n = cmd_ctl;
            host_next.cs_ctl_n = ~cmd_ctl;
            host_next.st = H_SETUP;
          end
        end else if (reset_req) begin
          host_next.cmd_ready = 1'b0;
          host_next.cnt = 8'h00;
          host_next.st = H_RST;
        end
      end
      H_DMAWAIT: begin
        // Acknowledge only answers a standing request.
        if (bus.dmarq) begin
          host_next.dmack_n = 1'b0;
          host_next.st = H_SETUP;
        end
      end
      H_SETUP: begin
        host_next.dior_n = host_reg.write;
        host_next.diow_n = ~host_reg.write;
        host_next.cnt = 8'h00;
        host_next.st = H_STROBE;
      end
      H_STROBE: begin
        if (host_reg.cnt != 8'hff) begin
          host_next.cnt = host_reg.cnt + 8'h01;
        end
        // The strobe is stretched while the drive holds ready low.
        if (host_reg.cnt >= 8'(STROBE_CYC - 1) && bus.iordy) begin
          host_next.dior_n = 1'b1;
          host_next.diow_n = 1'b1;
          host_next.rsp_data = host_reg.write ? 16'h0000 : bus.dd;
          host_next.rsp_valid = 1'b1;
          host_next.st = H_RECOVER;
        end
      end
      H_RECOVER: begin
        host_next.cs_cmd_n = 1'b1;
        host_next.cs_ctl_n = 1'b1;
        host_next.dmack_n = 1'b1;
        host_next.dd_oe_n = 1'b1;
        host_next.cmd_ready = 1'b1;
        host_next.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_reg <= HOST_RST;
    end else begin
      host_reg <= host_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign bus.cs_cmd_n = host_reg.cs_cmd_n;
  assign bus.cs_ctl_n = host_reg.cs_ctl_n;
  assign bus.da = host_reg.da;
  assign bus.dior_n = host_reg.dior_n;
  assign bus.diow_n = host_reg.diow_n;
  assign bus.dmack_n = host_reg.dmack_n;
  assign bus.host_dd_o = host_reg.dd_o;
  assign bus.host_dd_oe_n = host_reg.dd_oe_n;
  assign bus.host_interface_reset_in = host_reg.prst_n;
  assign cmd_ready = host_reg.cmd_ready;
  assign rsp_valid = host_reg.rsp_valid;
  assign rsp_data = host_reg.rsp_data;
  assign irq = host_reg.irq;
endmodule
`default_nettype wire

// [sim/ahps_assertions.sv]
// Concurrent checks on the wires between the host and drive ends.
`timescale 1ns/1ps
`default_nettype none
module ahps_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_cmd_n,
  input wire logic cs_ctl_n,
  input wire logic [2:0] da,
  input wire logic dior_n,
  input wire logic diow_n,
  input wire logic dmack_n,
  input wire logic dmarq,
  input wire logic iordy,
  input wire logic iocs16_n,
  input wire logic host_interrupt_request_out,
  input wire logic host_interface_reset_in,
  input wire logic host_dd_oe_n,
  input wire logic dev_dd_oe_n,
  input wire logic dasp_oe_n,
  input wire logic pdiag_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // Sequences and properties
  // ------------------------------------------------------------
  // A DMA read opens with the acknowledge and then the strobe.
  sequence s_dma_rd;
    $fell(dmack_n) ##1 $fell(dior_n);
  endsequence
  // The drive must then put a word on the bus in bounded time.
  sequence s_data_out;
    ##[1:60] !dev_dd_oe_n;
  endsequence
  chk_dma_data: assert property (s_dma_rd |-> s_data_out)
    else $error("dma read got no data");
  chk_ack_follows: assert property ($fell(dmack_n) |-> $past(dmarq))
    else $error("acknowledge without request");
  chk_word_dma_off: assert property (!dmack_n |-> iocs16_n)
    else $error("word indication during dma");
  // The word flag lags the select by one cycle, so a host reset is excluded.
  chk_word_tracks: assert property (disable iff (!rst_n || !host_interface_reset_in)
    iocs16_n == !$past(!cs_cmd_n && da == 3'h0 && dmack_n))
    else $error("word indication wrong");
  chk_select_onehot: assert property (!(!cs_cmd_n && !cs_ctl_n))
    else $error("both selects active");
  chk_strobe_select: assert property (($fell(dior_n) || $fell(diow_n)) |->
    ((cs_cmd_n ^ cs_ctl_n) && dmack_n) || (!dmack_n && cs_cmd_n && cs_ctl_n))
    else $error("strobe without one select");
  chk_strobe_width: assert property ($fell(dior_n) |-> !dior_n [*3])
    else $error("read strobe too short");
  chk_dd_read_only: assert property (!dev_dd_oe_n |-> (!dior_n || !$past(dior_n)))
    else $error("drive outputs data outside a read");
  chk_dd_no_clash: assert property (!(!dev_dd_oe_n && !host_dd_oe_n))
    else $error("both ends drive the data bus");
  chk_ready_end: assert property ($rose(dior_n) |-> $past(iordy))
    else $error("read ended while not ready");
  chk_host_reset: assert property (!host_interface_reset_in |=>
    !host_interrupt_request_out && dev_dd_oe_n && dasp_oe_n && pdiag_oe_n && iordy && !dmarq)
    else $error("host reset left drive outputs active");
endmodule
`default_nettype wire

// [sim/atapi_host_port_signals_tb_top.sv]
// Self-checking bench joining the host and drive ends of the port.
`timescale 1ns/1ps
`default_nettype none
`include "ahps_regs.svh"
module atapi_host_port_signals_tb_top;
  import ahps_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic is_drive1 = 1'b0, diag_done = 1'b0, dma_enable = 1'b0, irq_event = 1'b0, micro_event = 1'b0;
  logic push_valid = 1'b0, push_ready, host_wr_valid, dev_cmd_valid, dasp_seen, pdiag_seen;
  logic mia_oe_n, mib_oe_n, cmd_valid = 1'b0, cmd_write = 1'b0, cmd_ctl = 1'b0, cmd_dma = 1'b0;
  logic reset_req = 1'b0, cmd_ready, rsp_valid, irq, peer_dasp_n = 1'b1, peer_pdiag_n = 1'b1;
  logic cmd_seen = 1'b0, saw_wait = 1'b0, saw_prst = 1'b0;
  ahps_byte_t drive_status = 8'h00, config_register_eleven = 8'h00, cmd_code;
  ahps_word_t push_data = 16'h0000, host_wr_data, cmd_wdata = 16'h0000, rsp_data, wr_seen = 16'h0000;
  ahps_addr_t cmd_addr = 3'h0;
  int fail_count = 0;
  int cmp_count = 0;
  ahps_if bus_if ();
  assign bus_if.peer_dasp_n = peer_dasp_n;
  assign bus_if.peer_pdiag_n = peer_pdiag_n;
  // ------------------------------------------------------------
  // Clock, instances and monitors
  // ------------------------------------------------------------
  always #50 clk = ~clk;
  ahps_device i_ahps_device (.clk, .rst_n, .bus(bus_if), .is_drive1, .diag_done, .drive_status, .dma_enable,
    .irq_event, .micro_event, .config_register_eleven, .push_valid, .push_data, .push_ready, .host_wr_valid,
    .host_wr_data, .cmd_valid(dev_cmd_valid), .cmd_code, .dasp_seen, .pdiag_seen,
    .micro_interrupt_line_a_o(), .micro_interrupt_line_a_oe_n(mia_oe_n),
    .micro_interrupt_line_b_o(), .micro_interrupt_line_b_oe_n(mib_oe_n));
  ahps_host i_ahps_host (.clk, .rst_n, .bus(bus_if), .cmd_valid, .cmd_ready, .cmd_write, .cmd_ctl, .cmd_dma,
    .cmd_addr, .cmd_wdata, .reset_req, .rsp_valid, .rsp_data, .irq);
  ahps_assertions i_ahps_assertions (.clk, .rst_n, .cs_cmd_n(bus_if.cs_cmd_n),
    .cs_ctl_n(bus_if.cs_ctl_n), .da(bus_if.da), .dior_n(bus_if.dior_n), .diow_n(bus_if.diow_n),
    .dmack_n(bus_if.dmack_n), .dmarq(bus_if.dmarq), .iordy(bus_if.iordy), .iocs16_n(bus_if.iocs16_n),
    .host_interrupt_request_out(bus_if.host_interrupt_request_out),
    .host_interface_reset_in(bus_if.host_interface_reset_in), .host_dd_oe_n(bus_if.host_dd_oe_n),
    .dev_dd_oe_n(bus_if.dev_dd_oe_n), .dasp_oe_n(bus_if.dasp_oe_n), .pdiag_oe_n(bus_if.pdiag_oe_n));
  // Pulses last one cycle, so they are caught here rather than polled.
  always @(posedge clk) begin
    if (host_wr_valid === 1'b1) wr_seen <= host_wr_data;
    if (dev_cmd_valid === 1'b1) cmd_seen <= 1'b1;
    if (bus_if.iordy === 1'b0) saw_wait <= 1'b1;
    if (bus_if.host_interface_reset_in === 1'b0) saw_prst <= 1'b1;
  end
  // ------------------------------------------------------------
  // Checks and scenarios
  // ------------------------------------------------------------
  task automatic bump(input string msg);
    fail_count++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask
  task automatic cmp_word(input ahps_word_t got, input ahps_word_t exp);
    cmp_count++;
    if (got !== exp) bump($sformatf("word %h, expected %h", got, exp));
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) bump($sformatf("bit %b, expected %b", got, exp));
  endtask
  task automatic waitn(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Requests only go out while the host end shows it is idle.
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) bump("host never ready");
  endtask
  task automatic host_cmd(input logic w, input logic c, input logic d, input ahps_addr_t a,
      input ahps_word_t wd, output ahps_word_t rd);
    int n;
    wait_ready();
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_ctl = c;
    cmd_dma = d;
    cmd_addr = a;
    cmd_wdata = wd;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n >= 300) bump("no response");
    rd = rsp_data;
  endtask
  task automatic rd_cmp(input logic c, input logic d, input ahps_addr_t a, input ahps_word_t exp);
    ahps_word_t r;
    host_cmd(1'b0, c, d, a, 16'h0000, r);
    cmp_word(r, exp);
  endtask
  task automatic wr(input logic c, input ahps_addr_t a, input ahps_word_t wd);
    ahps_word_t r;
    host_cmd(1'b1, c, 1'b0, a, wd, r);
    waitn(3);
  endtask
  task automatic irq_pulse();
    @(negedge clk);
    irq_event = 1'b1;
    @(negedge clk);
    irq_event = 1'b0;
    waitn(4);
  endtask
  task automatic t_regs();
    drive_status = 8'h5a;
    rd_cmp(1'b0, 1'b0, `AHPS_DA_STATUS, 16'h005a);
    rd_cmp(1'b1, 1'b0, `AHPS_DA_DEVCTL, 16'h005a);
    rd_cmp(1'b1, 1'b0, 3'h5, 16'h0000);
  endtask
  // Fill until refused, then drain by register and by DMA cycles.
  task automatic t_fifo();
    int i;
    @(negedge clk);
    push_valid = 1'b1;
    for (i = 0; i < 16; i++) begin
      push_data = 16'h1000 + 16'(i);
      @(negedge clk);
    end
    push_data = 16'hdead;
    @(negedge clk);
    cmp_bit(push_ready, 1'b0);
    push_valid = 1'b0;
    for (i = 0; i < 8; i++) rd_cmp(1'b0, 1'b0, `AHPS_DA_DATA, 16'h1000 + 16'(i));
    dma_enable = 1'b1;
    for (i = 8; i < 16; i++) rd_cmp(1'b0, 1'b1, `AHPS_DA_DATA, 16'h1000 + 16'(i));
    waitn(3);
    cmp_bit(bus_if.dmarq, 1'b0);
    dma_enable = 1'b0;
    saw_wait = 1'b0;
    fork
      rd_cmp(1'b0, 1'b0, `AHPS_DA_DATA, 16'h2222);
      begin
        waitn(20);
        push_valid = 1'b1;
        push_data = 16'h2222;
        @(negedge clk);
        push_valid = 1'b0;
      end
    join
    cmp_bit(saw_wait, 1'b1);
  endtask
  task automatic t_write();
    wr(1'b0, `AHPS_DA_DATA, 16'ha5c3);
    cmp_word(wr_seen, 16'ha5c3);
    cmd_seen = 1'b0;
    wr(1'b0, `AHPS_DA_STATUS, 16'h00a0);
    cmp_bit(cmd_seen, 1'b1);
    cmp_word({8'h00, cmd_code}, 16'h00a0);
    wr(1'b0, 3'h3, 16'h0033);
    rd_cmp(1'b0, 1'b0, 3'h3, 16'h0033);
  endtask
  task automatic t_irq();
    config_register_eleven = 8'h80;
    irq_pulse();
    cmp_bit(bus_if.host_interrupt_request_out, 1'b1);
    cmp_bit(mib_oe_n, 1'b0);
    cmp_bit(irq, 1'b1);
    rd_cmp(1'b0, 1'b0, `AHPS_DA_STATUS, 16'h005a);
    waitn(3);
    cmp_bit(bus_if.host_interrupt_request_out, 1'b0);
    config_register_eleven = 8'h00;
    irq_pulse();
    cmp_bit(mib_oe_n, 1'b1);
    wr(1'b1, `AHPS_DA_DEVCTL, 16'h0002);
    cmp_bit(bus_if.host_interrupt_request_out, 1'b0);
    wr(1'b1, `AHPS_DA_DEVCTL, 16'h0000);
    cmp_bit(bus_if.host_interrupt_request_out, 1'b1);
    wr(1'b1, `AHPS_DA_DEVCTL, 16'h0004);
    wr(1'b1, `AHPS_DA_DEVCTL, 16'h0000);
    cmp_bit(bus_if.host_interrupt_request_out, 1'b0);
    micro_event = 1'b1;
    waitn(3);
    cmp_bit(mia_oe_n, 1'b0);
    micro_event = 1'b0;
  endtask
  task automatic t_drives();
    is_drive1 = 1'b1;
    waitn(3);
    cmp_bit(bus_if.dasp_oe_n, 1'b0);
    cmp_bit(bus_if.pdiag_oe_n, 1'b1);
    diag_done = 1'b1;
    waitn(3);
    cmp_bit(bus_if.pdiag_oe_n, 1'b0);
    is_drive1 = 1'b0;
    peer_dasp_n = 1'b0;
    peer_pdiag_n = 1'b0;
    waitn(3);
    cmp_bit(bus_if.dasp_oe_n, 1'b1);
    cmp_bit(dasp_seen, 1'b1);
    cmp_bit(pdiag_seen, 1'b1);
    peer_dasp_n = 1'b1;
    peer_pdiag_n = 1'b1;
  endtask
  // A host reset must wipe a pending interrupt in the drive.
  task automatic t_prst();
    irq_pulse();
    cmp_bit(bus_if.host_interrupt_request_out, 1'b1);
    saw_prst = 1'b0;
    wait_ready();
    reset_req = 1'b1;
    @(negedge clk);
    reset_req = 1'b0;
    waitn(30);
    cmp_bit(saw_prst, 1'b1);
    cmp_bit(bus_if.host_interrupt_request_out, 1'b0);
    rd_cmp(1'b0, 1'b0, `AHPS_DA_STATUS, 16'h005a);
  endtask
  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_regs();
    t_fifo();
    t_write();
    t_irq();
    t_drives();
    t_prst();
    conclude();
  end
  // The scenarios need several hundred cycles; this margin catches a hang.
  initial begin
    repeat (20000) @(posedge clk);
    bump("watchdog expired");
    conclude();
  end
endmodule
`default_nettype wire
